// ---- usbp_chk.sv ----
// Concurrent checks on the serial port pins
`timescale 1ns/1ps
module usbp_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic bus_ce_n,
	input wire logic bus_wr,
	input wire logic [1:0] bus_a,
	input wire logic [7:0] bus_d_in,
	input wire logic bus_d_oe,
	input wire logic set_ready_n,
	input wire logic carrier_present_in,
	input wire logic clear_to_send_n,
	input wire logic transmit_bit_clock,
	input wire logic serial_out,
	input wire logic terminal_ready_n,
	input wire logic request_send_n,
	input wire logic rx_char_waiting_n_oe,
	input wire logic tx_empty_or_modem_change_n_oe
);
	// Windows of five allow for the two-flop pin synchronisers
	a_bus_float_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_ce_n [*5] |-> !bus_d_oe) else $error("bus driven while deselected");
	a_read_drives_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!bus_ce_n && !bus_wr) [*5] |-> bus_d_oe) else $error("read not driven");
	a_write_keeps_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!bus_ce_n && bus_wr) [*5] |-> !bus_d_oe) else $error("bus driven on write");
	a_cmd_pins_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		($rose(bus_ce_n) && bus_wr && bus_a == 2'h3) |-> ##5
		(terminal_ready_n == !$past(bus_d_in[1], 5) && request_send_n == !$past(bus_d_in[5], 5)))
		else $error("modem outputs wrong");
	a_rx_read_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		($rose(bus_ce_n) && !bus_wr && bus_a == 2'h0) |-> ##5 !rx_char_waiting_n_oe)
		else $error("receive ready kept");
	a_dsr_change_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		$changed(set_ready_n) |-> ##[1:8] tx_empty_or_modem_change_n_oe)
		else $error("set ready change missed");
	a_dcd_change_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		$changed(carrier_present_in) |-> ##[1:8] tx_empty_or_modem_change_n_oe)
		else $error("carrier change missed");
	// Reset is the condition here, so it cannot also disable the check
	a_reset_quiets_pins: assert property (@(posedge core_clk)
		(!rst_n) [*2] |-> (!bus_d_oe && !rx_char_waiting_n_oe && terminal_ready_n
		&& request_send_n && !tx_empty_or_modem_change_n_oe)) else $error("reset not idle");
	a_cts_holds_mark: assert property (@(negedge transmit_bit_clock) disable iff (!rst_n)
		clear_to_send_n [*5] |-> serial_out) else $error("line not at mark");
endmodule // usbp_chk

bind usbp_top usbp_chk u_usbp_chk (
	.core_clk,
	.rst_n,
	.bus_ce_n,
	.bus_wr,
	.bus_a,
	.bus_d_in,
	.bus_d_oe,
	.set_ready_n,
	.carrier_present_in,
	.clear_to_send_n,
	.transmit_bit_clock,
	.serial_out,
	.terminal_ready_n,
	.request_send_n,
	.rx_char_waiting_n_oe,
	.tx_empty_or_modem_change_n_oe
);

// ---- usbp_modem.sv ----
// Modem-side model: bit clocks, serial source and sink
`timescale 1ns/1ps
module usbp_modem (
	output logic transmit_bit_clock,
	output logic receive_bit_clock,
	output logic serial_in,
	input wire logic serial_out
);
	logic bclk_q = 1'b0;
	// External 1x bit clocks; no baud reference needed then
	initial begin
		serial_in = 1'b1;
		#17;
		forever #62.5 bclk_q = ~bclk_q;
	end
	assign transmit_bit_clock = bclk_q;
	assign receive_bit_clock = bclk_q;
	// Change on the falling edge, device samples on the rising one
	task automatic send_char(input logic [7:0] b);
		@(negedge receive_bit_clock) serial_in <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge receive_bit_clock) serial_in <= b[i];
		end
		@(negedge receive_bit_clock) serial_in <= 1'b1;
		@(negedge receive_bit_clock);
	endtask
	// Device shifts on the falling edge, so take bits mid-cell
	task automatic get_char(output logic [7:0] b);
		int n;
		n = 0;
		b = 8'hxx;
		while (serial_out !== 1'b0 && n < 400) begin
			@(posedge transmit_bit_clock);
			n++;
		end
		if (n < 400) begin
			for (int i = 0; i < 8; i++) begin
				@(posedge transmit_bit_clock);
				b[i] = serial_out;
			end
			@(posedge transmit_bit_clock);
			if (serial_out !== 1'b1) begin
				b = 8'hxx;
			end
		end
	endtask
endmodule // usbp_modem

// ---- usbp_params.svh ----
// Register offsets, bit positions, reset values and timing counts
`ifndef USBP_PARAMS_SVH
`define USBP_PARAMS_SVH
`define USBP_A_HOLD 2'h0
`define USBP_A_SYNC 2'h1
`define USBP_A_MODE 2'h2
`define USBP_A_CMD 2'h3
`define USBP_REG_RST 8'h00
`define USBP_CMD_TXEN 0
`define USBP_CMD_DTR 1
`define USBP_CMD_RECEIVER_ON 2
`define USBP_CMD_ERRCLR 4
`define USBP_CMD_RTS 5
`define USBP_SR_TX_HOLDING_FREE_N 0
`define USBP_SR_RX_CHAR_WAITING_N 1
`define USBP_SR_EMPTY 2
`define USBP_SR_OVR 4
`define USBP_SR_FE 5
`define USBP_SR_DCD 6
`define USBP_SR_DSR 7
`define USBP_MR2_TXCLK 5
`define USBP_MR2_RXCLK 4
`define USBP_SYN_LAST 2'h2
`define USBP_FRAME_BITS 4'hA
`define USBP_DATA_LAST 3'h7
`define USBP_BIT_DIV 16'h0040
`endif

// ---- usbp_pkg.sv ----
// Types shared by the serial port design
package usbp_pkg;
	typedef enum logic [2:0] {
		USBP_RX_IDLE = 3'h1,
		USBP_RX_DATA = 3'h2,
		USBP_RX_STOP = 3'h4
	} usbp_rx_state_t;
endpackage

// ---- usbp_top.sv ----
// Serial port: CPU bus registers, modem pins and bit-clock link logic
// Functional notes
// - Reset clears mode, command, status; goes idle
// - Bus acts and drives only while enabled
// - Write line high writes, low reads
// - Read decode: holding, status, mode, command
// - Write decode: holding, sync group, mode, command
// - Group accesses step to next register
// - Pointer wraps after last group register
// - Pointers reset by reset or command read
// - Status bit 7 inverse ready; change flags
// - Receiver needs carrier; bit 6; change flags
// - Transmitter needs clear-to-send; else mark
// - Transmit ready pin is inverse status bit 0 while command bit 0 is set
// - Receive ready pin; cleared by read/disable
// - Empty/change pin is inverse status bit 2
// - Status read clears change unless empty
// - Disabled transmitter holds line at mark
// - Terminal ready, request pins invert command bits
// - Receive clock rising edge samples; internal drives
// - Transmit falling edge shifts; internal drives
// - Command bits 0 and 2 enable tx, rx
`timescale 1ns/1ps
`include "usbp_params.svh"

module usbp_top
	import usbp_pkg::*;
#(
	parameter logic [15:0] BIT_DIV = `USBP_BIT_DIV
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic bus_ce_n,
	input wire logic bus_wr,
	input wire logic [1:0] bus_a,
	input wire logic [7:0] bus_d_in,
	output logic [7:0] bus_d_out,
	output logic bus_d_oe,
	input wire logic set_ready_n,
	input wire logic carrier_present_in,
	input wire logic clear_to_send_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic terminal_ready_n,
	output logic request_send_n,
	output logic tx_holding_free_n,
	output logic tx_holding_free_n_oe,
	output logic rx_char_waiting_n,
	output logic rx_char_waiting_n_oe,
	output logic tx_empty_or_modem_change_n,
	output logic tx_empty_or_modem_change_n_oe,
	input wire logic transmit_bit_clock,
	output logic transmit_bit_clock_out,
	output logic transmit_bit_clock_oe,
	input wire logic receive_bit_clock,
	output logic receive_bit_clock_out,
	output logic receive_bit_clock_oe
);

	// Pin synchronisers: {ce_n, wr, a, d, dsr_n, dcd_n, cts_n}
	logic [14:0] pin_s1_q;
	logic [14:0] pin_s2_q;
	logic ce_s3_q;
	logic ce_s;
	logic wr_s;
	logic [1:0] a_s;
	logic [7:0] d_s;
	logic dsr_s;
	logic dcd_s;
	logic cts_s;

	always_ff @(posedge core_clk) begin
		pin_s1_q <= {bus_ce_n, bus_wr, bus_a, bus_d_in,
			set_ready_n, carrier_present_in, clear_to_send_n};
		pin_s2_q <= pin_s1_q;
		ce_s3_q <= ce_s;
	end

	assign {ce_s, wr_s, a_s, d_s, dsr_s, dcd_s, cts_s} = pin_s2_q;

	// Access captured while enabled, acted on when enable rises
	logic acc_wr_q;
	logic [1:0] acc_a_q;
	logic [7:0] acc_d_q;
	logic acc_end;

	always_ff @(posedge core_clk) begin
		if (!ce_s) begin
			acc_wr_q <= wr_s;
			acc_a_q <= a_s;
			acc_d_q <= d_s;
		end
	end

	assign acc_end = ce_s && !ce_s3_q && rst_n;

	logic wr_end;
	logic rd_end;
	assign wr_end = acc_end && acc_wr_q;
	assign rd_end = acc_end && !acc_wr_q;

	// Configuration registers
	logic [7:0] mode_one_q;
	logic [7:0] mode_two_q;
	logic [7:0] command_control_q;
	logic [7:0] sync_char_first_q;
	logic [7:0] sync_char_second_q;
	logic [7:0] link_escape_char_q;
	logic [7:0] transmit_char_holding_q;
	logic mode_ptr_q;
	logic [1:0] syn_ptr_q;
	logic tx_on;
	logic receiver_on;

	assign tx_on = command_control_q[`USBP_CMD_TXEN];
	assign receiver_on = command_control_q[`USBP_CMD_RECEIVER_ON];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_one_q <= `USBP_REG_RST;
			mode_two_q <= `USBP_REG_RST;
			command_control_q <= `USBP_REG_RST;
		end else if (wr_end && acc_a_q == `USBP_A_MODE) begin
			if (!mode_ptr_q)
				mode_one_q <= acc_d_q;
			else
				mode_two_q <= acc_d_q;
		end else if (wr_end && acc_a_q == `USBP_A_CMD) begin
			command_control_q <= acc_d_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync_char_first_q <= `USBP_REG_RST;
			sync_char_second_q <= `USBP_REG_RST;
			link_escape_char_q <= `USBP_REG_RST;
		end else if (wr_end && acc_a_q == `USBP_A_SYNC) begin
			case (syn_ptr_q)
				2'h0: sync_char_first_q <= acc_d_q;
				2'h1: sync_char_second_q <= acc_d_q;
				default: link_escape_char_q <= acc_d_q;
			endcase
		end
	end

	// Mode pointer steps on reads and writes; command read rewinds
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			mode_ptr_q <= 1'b0;
		else if (rd_end && acc_a_q == `USBP_A_CMD)
			mode_ptr_q <= 1'b0;
		else if (acc_end && acc_a_q == `USBP_A_MODE)
			mode_ptr_q <= !mode_ptr_q;
	end

	// Reads at the sync address return status, so only writes step it
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			syn_ptr_q <= 2'h0;
		else if (rd_end && acc_a_q == `USBP_A_CMD)
			syn_ptr_q <= 2'h0;
		else if (wr_end && acc_a_q == `USBP_A_SYNC) begin
			if (syn_ptr_q == `USBP_SYN_LAST)
				syn_ptr_q <= 2'h0;
			else
				syn_ptr_q <= syn_ptr_q + 2'h1;
		end
	end

	// Transmit handoff: toggle request, data replaced by any later holding write
	logic ld_tgl_q;
	logic [1:0] ack_s_q;
	logic tx_pending;
	logic thr_wr;

	assign thr_wr = wr_end && acc_a_q == `USBP_A_HOLD;
	assign tx_pending = ld_tgl_q != ack_s_q[1];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ld_tgl_q <= 1'b0;
			transmit_char_holding_q <= `USBP_REG_RST;
		end else if (thr_wr) begin
			transmit_char_holding_q <= acc_d_q;
			// A second write before pickup replaces the character
			if (!tx_pending)
				ld_tgl_q <= !ld_tgl_q;
		end
	end

	// Link-side status crossing into the core domain
	logic tx_seen_q;
	logic tx_idle_q;
	logic [1:0] tx_idle_s_q;
	logic tx_empty_cond_q;
	logic rx_done_tgl_q;
	logic [2:0] rx_done_s_q;
	logic [7:0] rx_data_q;
	logic rx_fe_q;

	always_ff @(posedge core_clk) begin
		ack_s_q <= {ack_s_q[0], tx_seen_q};
		tx_idle_s_q <= {tx_idle_s_q[0], tx_idle_q};
		rx_done_s_q <= {rx_done_s_q[1:0], rx_done_tgl_q};
	end

	// Status flags
	logic rx_rdy_q;
	logic overrun_q;
	logic frame_err_q;
	logic tx_empty_q;
	logic modem_chg_q;
	logic dsr_prev_q;
	logic dcd_prev_q;
	logic [7:0] received_char_holding_q;
	logic rx_new;
	logic err_clr;
	logic tx_empty_now;

	assign rx_new = rx_done_s_q[2] != rx_done_s_q[1];
	assign err_clr = wr_end && acc_a_q == `USBP_A_CMD
		&& acc_d_q[`USBP_CMD_ERRCLR];
	assign tx_empty_now = tx_idle_s_q[1] && !tx_pending && tx_on;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			received_char_holding_q <= `USBP_REG_RST;
		else if (rx_new && receiver_on)
			received_char_holding_q <= rx_data_q;
	end

	// Set wins over clear on every flag below
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rx_rdy_q <= 1'b0;
		else if (rx_new && receiver_on)
			rx_rdy_q <= 1'b1;
		else if (!receiver_on)
			rx_rdy_q <= 1'b0;
		else if (rd_end && acc_a_q == `USBP_A_HOLD)
			rx_rdy_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			overrun_q <= 1'b0;
			frame_err_q <= 1'b0;
		end else begin
			if (rx_new && receiver_on && rx_rdy_q)
				overrun_q <= 1'b1;
			else if (err_clr)
				overrun_q <= 1'b0;
			if (rx_new && receiver_on && rx_fe_q)
				frame_err_q <= 1'b1;
			else if (err_clr)
				frame_err_q <= 1'b0;
		end
	end

	// Empty latches on the edge into idle; only a load clears it
	logic tx_empty_prev_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_empty_q <= 1'b0;
			tx_empty_prev_q <= 1'b0;
		end else begin
			tx_empty_prev_q <= tx_empty_now;
			if (tx_empty_now && !tx_empty_prev_q)
				tx_empty_q <= 1'b1;
			else if (thr_wr)
				tx_empty_q <= 1'b0;
		end
	end

	// Modem change; prev tracks the pin in reset so release is no edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			modem_chg_q <= 1'b0;
			dsr_prev_q <= dsr_s;
			dcd_prev_q <= dcd_s;
		end else begin
			dsr_prev_q <= dsr_s;
			dcd_prev_q <= dcd_s;
			if (dsr_s != dsr_prev_q || dcd_s != dcd_prev_q)
				modem_chg_q <= 1'b1;
			else if (rd_end && acc_a_q == `USBP_A_SYNC)
				modem_chg_q <= 1'b0;
		end
	end

	logic [7:0] line_status;

	always_comb begin
		line_status = `USBP_REG_RST;
		line_status[`USBP_SR_DSR] = !dsr_s;
		line_status[`USBP_SR_DCD] = !dcd_s;
		line_status[`USBP_SR_FE] = frame_err_q;
		line_status[`USBP_SR_OVR] = overrun_q;
		line_status[`USBP_SR_EMPTY] = tx_empty_q || modem_chg_q;
		line_status[`USBP_SR_RX_CHAR_WAITING_N] = rx_rdy_q;
		line_status[`USBP_SR_TX_HOLDING_FREE_N] = !tx_pending;
	end

	// Read data path
	logic [7:0] rd_mux;

	always_comb begin
		case (a_s)
			`USBP_A_HOLD: rd_mux = received_char_holding_q;
			`USBP_A_SYNC: rd_mux = line_status;
			`USBP_A_MODE: rd_mux = mode_ptr_q ? mode_two_q : mode_one_q;
			`USBP_A_CMD: rd_mux = command_control_q;
			default: rd_mux = `USBP_REG_RST;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_d_out <= `USBP_REG_RST;
			bus_d_oe <= 1'b0;
		end else begin
			bus_d_out <= rd_mux;
			bus_d_oe <= !ce_s && !wr_s;
		end
	end

	// Modem and ready outputs; open-drain pins pull low only
	assign terminal_ready_n = !command_control_q[`USBP_CMD_DTR];
	assign request_send_n = !command_control_q[`USBP_CMD_RTS];
	assign tx_holding_free_n = 1'b0;
	assign tx_holding_free_n_oe = line_status[`USBP_SR_TX_HOLDING_FREE_N] && tx_on;
	assign rx_char_waiting_n = 1'b0;
	assign rx_char_waiting_n_oe = line_status[`USBP_SR_RX_CHAR_WAITING_N];
	assign tx_empty_or_modem_change_n = 1'b0;
	assign tx_empty_or_modem_change_n_oe = line_status[`USBP_SR_EMPTY];

	// Internal 1x bit clock drives both clock pins when selected
	logic [15:0] div_cnt_q;
	logic bit_clk_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_cnt_q <= 16'h0000;
			bit_clk_q <= 1'b0;
		end else if (div_cnt_q >= BIT_DIV - 16'h0001) begin
			div_cnt_q <= 16'h0000;
			bit_clk_q <= !bit_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	assign transmit_bit_clock_out = bit_clk_q;
	assign transmit_bit_clock_oe = mode_two_q[`USBP_MR2_TXCLK];
	assign receive_bit_clock_out = bit_clk_q;
	assign receive_bit_clock_oe = mode_two_q[`USBP_MR2_RXCLK];

	// Transmit domain, shifts on falling edge of the bit clock
	logic tx_go;
	logic [1:0] tx_go_s_q;
	logic [1:0] tx_rst_s_q;
	logic [1:0] tld_s_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_cnt_q;

	assign tx_go = tx_on && !cts_s;

	always_ff @(negedge transmit_bit_clock) begin
		tx_rst_s_q <= {tx_rst_s_q[0], rst_n};
		tx_go_s_q <= {tx_go_s_q[0], tx_go};
		tld_s_q <= {tld_s_q[0], ld_tgl_q};
	end

	assign tx_idle_q = tx_cnt_q == 4'h0;

	always_ff @(negedge transmit_bit_clock) begin
		if (!tx_rst_s_q[1]) begin
			tx_cnt_q <= 4'h0;
			tx_sh_q <= 10'h3FF;
			tx_seen_q <= 1'b0;
		end else if (tx_go_s_q[1]) begin
			if (tx_cnt_q != 4'h0) begin
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_cnt_q <= tx_cnt_q - 4'h1;
			end else if (tld_s_q[1] != tx_seen_q) begin
				// Data may change: a core write before the ack returns replaces it
				tx_sh_q <= {1'b1, transmit_char_holding_q, 1'b0};
				tx_cnt_q <= `USBP_FRAME_BITS;
				tx_seen_q <= tld_s_q[1];
			end
		end
	end

	always_ff @(negedge transmit_bit_clock) begin
		if (!tx_rst_s_q[1] || !tx_go_s_q[1] || tx_cnt_q == 4'h0)
			serial_out <= 1'b1;
		else
			serial_out <= tx_sh_q[0];
	end

	// Receive domain, samples on rising edge of the bit clock
	usbp_rx_state_t rx_st_q;
	logic rx_go;
	logic [1:0] rx_go_s_q;
	logic [1:0] rx_rst_s_q;
	logic [1:0] rxd_s_q;
	logic [7:0] rx_sh_q;
	logic [2:0] rx_cnt_q;

	assign rx_go = receiver_on && !dcd_s;

	always_ff @(posedge receive_bit_clock) begin
		rx_rst_s_q <= {rx_rst_s_q[0], rst_n};
		rx_go_s_q <= {rx_go_s_q[0], rx_go};
		rxd_s_q <= {rxd_s_q[0], serial_in};
	end

	always_ff @(posedge receive_bit_clock) begin
		if (!rx_rst_s_q[1]) begin
			rx_st_q <= USBP_RX_IDLE;
			rx_cnt_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_data_q <= 8'h00;
			rx_fe_q <= 1'b0;
			rx_done_tgl_q <= 1'b0;
		end else begin
			case (rx_st_q)
				USBP_RX_IDLE: begin
					rx_cnt_q <= 3'h0;
					if (rx_go_s_q[1] && !rxd_s_q[1])
						rx_st_q <= USBP_RX_DATA;
				end
				USBP_RX_DATA: begin
					rx_sh_q <= {rxd_s_q[1], rx_sh_q[7:1]};
					rx_cnt_q <= rx_cnt_q + 3'h1;
					if (rx_cnt_q == `USBP_DATA_LAST)
						rx_st_q <= USBP_RX_STOP;
				end
				USBP_RX_STOP: begin
					// Handed over only when the core may accept it
					rx_data_q <= rx_sh_q;
					rx_fe_q <= !rxd_s_q[1];
					if (rx_go_s_q[1])
						rx_done_tgl_q <= !rx_done_tgl_q;
					rx_st_q <= USBP_RX_IDLE;
				end
				default: rx_st_q <= USBP_RX_IDLE;
			endcase
		end
	end

endmodule // usbp_top

// ---- usbp_top_tb.sv ----
// Self-checking bench for the serial port bus and pins
`timescale 1ns/1ps
module usbp_top_tb;
	typedef struct {logic wr; logic [1:0] a; logic [7:0] d; logic [7:0] m;} usbp_row_t;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic bus_ce_n = 1'b1;
	logic bus_wr = 1'b0;
	logic [1:0] bus_a = 2'h0;
	logic [7:0] bus_d_in = 8'h00;
	logic set_ready_n = 1'b0;
	logic carrier_present_in = 1'b0;
	logic clear_to_send_n = 1'b0;
	logic [7:0] bus_d_out, q, r;
	logic bus_d_oe, serial_in, serial_out, terminal_ready_n, request_send_n, m_txc, m_rxc;
	logic tx_holding_free_n, tx_holding_free_n_oe, rx_char_waiting_n, rx_char_waiting_n_oe;
	logic tx_empty_or_modem_change_n, tx_empty_or_modem_change_n_oe;
	logic transmit_bit_clock, transmit_bit_clock_out, transmit_bit_clock_oe;
	logic receive_bit_clock, receive_bit_clock_out, receive_bit_clock_oe;
	int n_errors = 0;
	int n_compared = 0;
	usbp_row_t rows [12] = '{
		'{1'b1, 2'h3, 8'h22, 8'hFF},
		'{1'b0, 2'h3, 8'h22, 8'hFF},
		'{1'b1, 2'h2, 8'h4E, 8'hFF},
		'{1'b1, 2'h2, 8'h0F, 8'hFF},
		'{1'b0, 2'h2, 8'h4E, 8'hFF},
		'{1'b0, 2'h2, 8'h0F, 8'hFF},
		'{1'b0, 2'h2, 8'h4E, 8'hFF},
		'{1'b1, 2'h1, 8'h55, 8'hFF},
		'{1'b0, 2'h2, 8'h0F, 8'hFF},
		'{1'b0, 2'h3, 8'h22, 8'hFF},
		'{1'b0, 2'h2, 8'h4E, 8'hFF},
		'{1'b0, 2'h1, 8'hC0, 8'hC0}
	};
	always #20 core_clk = ~core_clk;
	assign transmit_bit_clock = transmit_bit_clock_oe ? transmit_bit_clock_out : m_txc;
	assign receive_bit_clock = receive_bit_clock_oe ? receive_bit_clock_out : m_rxc;
	usbp_top u_usbp_top (
		.core_clk, .rst_n, .bus_ce_n, .bus_wr, .bus_a, .bus_d_in, .bus_d_out, .bus_d_oe,
		.set_ready_n, .carrier_present_in, .clear_to_send_n, .serial_in, .serial_out,
		.terminal_ready_n, .request_send_n, .tx_holding_free_n, .tx_holding_free_n_oe,
		.rx_char_waiting_n, .rx_char_waiting_n_oe, .tx_empty_or_modem_change_n,
		.tx_empty_or_modem_change_n_oe, .transmit_bit_clock, .transmit_bit_clock_out,
		.transmit_bit_clock_oe, .receive_bit_clock, .receive_bit_clock_out,
		.receive_bit_clock_oe
	);
	usbp_modem u_usbp_modem (
		.transmit_bit_clock(m_txc),
		.receive_bit_clock(m_rxc),
		.serial_in,
		.serial_out
	);
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %b got %b", nm, e, s);
		end
	endtask
	// Chip enable held 320 ns, well past the synchronisers
	task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		@(posedge core_clk);
		bus_ce_n <= 1'b0;
		bus_wr <= wr;
		bus_a <= a;
		bus_d_in <= d;
		repeat (8) @(posedge core_clk);
		rd = bus_d_out;
		chk1("bus_d_oe", !wr, bus_d_oe);
		bus_ce_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk1("bus_d_oe", 1'b0, bus_d_oe);
	endtask
	task automatic results();
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		results();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		// Mode and command written before any traffic
		for (int i = 0; i < 12; i++) begin
			acc(rows[i].wr, rows[i].a, rows[i].d, q);
			if (!rows[i].wr) begin
				chk8($sformatf("row%0d", i), rows[i].d, q & rows[i].m);
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (i == 0) begin
				set_ready_n <= 1'b1;
			end else begin
				carrier_present_in <= 1'b1;
			end
			repeat (12) @(posedge core_clk);
			chk1("change", 1'b1, tx_empty_or_modem_change_n_oe);
			acc(1'b0, 2'h1, 8'h00, q);
			chk8("status", (i == 0) ? 8'h40 : 8'h00, q & 8'hC0);
			chk1("change", 1'b0, tx_empty_or_modem_change_n_oe);
		end
		set_ready_n <= 1'b0;
		carrier_present_in <= 1'b0;
		repeat (12) @(posedge core_clk);
		acc(1'b0, 2'h1, 8'h00, q);
		clear_to_send_n <= 1'b1;
		acc(1'b1, 2'h3, 8'h05, q);
		chk1("tx_holding_free_n", 1'b1, tx_holding_free_n_oe);
		acc(1'b1, 2'h0, 8'h5A, q);
		repeat (40) @(posedge core_clk);
		chk1("tx_holding_free_n", 1'b0, tx_holding_free_n_oe);
		chk1("txd", 1'b1, serial_out);
		clear_to_send_n <= 1'b0;
		u_usbp_modem.get_char(r);
		chk8("txchar", 8'h5A, r);
		repeat (12) @(posedge core_clk);
		chk1("empty", 1'b1, tx_empty_or_modem_change_n_oe);
		acc(1'b0, 2'h1, 8'h00, q);
		chk1("empty", 1'b1, tx_empty_or_modem_change_n_oe);
		// Start bit leaves only after the bus cycle ends; listening starts first
		fork
			u_usbp_modem.get_char(r);
		join_none
		acc(1'b1, 2'h0, 8'hC3, q);
		chk1("empty", 1'b0, tx_empty_or_modem_change_n_oe);
		wait fork;
		chk8("txchar", 8'hC3, r);
		acc(1'b1, 2'h3, 8'h04, q);
		chk1("txd", 1'b1, serial_out);
		chk1("tx_holding_free_n", 1'b0, tx_holding_free_n_oe);
		u_usbp_modem.send_char(8'h96);
		repeat (10) @(posedge core_clk);
		chk1("rx_char_waiting_n", 1'b1, rx_char_waiting_n_oe);
		acc(1'b0, 2'h0, 8'h00, q);
		chk8("rxchar", 8'h96, q);
		chk1("rx_char_waiting_n", 1'b0, rx_char_waiting_n_oe);
		carrier_present_in <= 1'b1;
		repeat (12) @(posedge core_clk);
		u_usbp_modem.send_char(8'h3C);
		repeat (10) @(posedge core_clk);
		chk1("rx_char_waiting_n", 1'b0, rx_char_waiting_n_oe);
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		acc(1'b0, 2'h3, 8'h00, q);
		chk8("cmd", 8'h00, q);
		acc(1'b0, 2'h2, 8'h00, q);
		chk8("mode", 8'h00, q);
		chk1("dtr", 1'b1, terminal_ready_n);
		results();
	end
endmodule // usbp_top_tb
